/* File: core/sbsi_core.sv */
`timescale 1ns/1ps
module sbsi_core
    import sbsi_pkg::*;
(
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_b_i,
    input  wire logic [sbsi_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [sbsi_pkg::DATA_W-1:0] data_i,
    output logic      [sbsi_pkg::DATA_W-1:0] data_o,
    output logic                             data_oe_o,
    input  wire logic                        chip_select_n_i,
    input  wire logic                        secondary_selects_n_i,
    input  wire logic                        secondary_selects_i,
    input  wire logic                        load_or_step_n_i,
    input  wire logic                        read_write_n_i,
    input  wire logic                        lane_a_write_n_i,
    input  wire logic                        lane_b_write_n_i,
    input  wire logic                        lane_c_write_n_i,
    input  wire logic                        lane_d_write_n_i,
    input  wire logic                        clock_suspend_n_i,
    input  wire logic                        output_enable_n_i,
    input  wire logic                        sleep_request_i,
    input  wire logic                        burst_interleave_i
);
    import sbsi_pkg::*;

    // address phase state, fixed at load edges
    sbsi_cyc_t          cyc_reg;
    sbsi_cyc_t          cyc_next;
    logic [HI_W-1:0]    hi_reg;
    logic [HI_W-1:0]    hi_next;
    logic [LANES-1:0]   lanes_reg;
    logic [LANES-1:0]   lanes_next;

    // data phase state
    logic               drive_reg;
    logic               drive_next;

    logic               run;
    logic               is_load;
    logic               selected;
    logic [LANES-1:0]   lanes_in;

    sbsi_burst_if       burst ();
    sbsi_mem_if         mem ();

    // sleep ignores every input; suspend freezes every edge
    assign run = !sleep_request_i && !clock_suspend_n_i;   // see R15, R19
    assign is_load = run && !load_or_step_n_i;             // see R05

    assign selected = !chip_select_n_i
                   && !secondary_selects_n_i
                   && secondary_selects_i;                 // see R12

    assign lanes_in = ~{lane_d_write_n_i, lane_c_write_n_i,
                        lane_b_write_n_i, lane_a_write_n_i};

    // burst counter drive
    assign burst.load       = is_load;                     // see R07
    assign burst.step       = run && load_or_step_n_i;     // see R06
    assign burst.base       = addr_i[BURST_W-1:0];
    assign burst.interleave = burst_interleave_i;          // see R17, R18

    sbsi_burst_counter u_burst
    (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .bus        (burst)
    );

    // array access for the beat held in the address phase registers
    assign mem.addr    = {hi_reg, burst.beat};             // see R04
    assign mem.wr_en   = run && (cyc_reg == CYC_WRITE);    // see R08
    assign mem.lane_en = lanes_reg;                        // see R10
    assign mem.wdata   = data_i;
    assign mem.rd_en   = run && (cyc_reg == CYC_READ);     // see R01

    sbsi_array u_array
    (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .port       (mem)
    );

    always_comb
    begin
        cyc_next   = cyc_reg;
        hi_next    = hi_reg;
        lanes_next = lanes_reg;
        if (is_load)
        begin
            hi_next    = addr_i[ADDR_W-1:BURST_W];
            lanes_next = lanes_in;                         // see R09, R20
            if (!selected)                                 // see R13
            begin
                cyc_next = CYC_DESEL;                      // see R22
            end
            else if (read_write_n_i)
            begin
                cyc_next = CYC_READ;                       // see R11
            end
            else
            begin
                cyc_next = CYC_WRITE;                      // see R08
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cyc_reg   <= CYC_DESEL;
            hi_reg    <= HI_ZERO;
            lanes_reg <= LANE_NONE;
        end
        else
        begin
            cyc_reg   <= cyc_next;                         // see R02
            hi_reg    <= hi_next;
            lanes_reg <= lanes_next;
        end
    end

    always_comb
    begin
        drive_next = drive_reg;
        if (sleep_request_i)
        begin
            drive_next = 1'b0;                             // see R19
        end
        else if (run)
        begin
            unique case (cyc_reg)
                CYC_READ:  drive_next = 1'b1;
                CYC_WRITE: drive_next = 1'b0;
                CYC_DESEL: drive_next = 1'b0;              // see R22
                default:   drive_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            drive_reg <= 1'b0;
        end
        else
        begin
            drive_reg <= drive_next;
        end
    end

    assign data_o = mem.rdata;
    // output enable acts without the clock, so it gates after the flop
    assign data_oe_o = drive_reg && !output_enable_n_i
                    && !sleep_request_i;                   // see R14
endmodule

/* File: core/sbsi_pkg.sv */
// Behaviour
// R01: a read or write may be issued every cycle, no idle cycles between.
// R02: all synchronous inputs are captured on the rising clock edge.
// R03: memory core is 256K words of 36 bits (512K x 18 is the other build).
// R04: a two-bit internal burst counter supplies the low address bits.
// R05: load_or_step_n low loads a new address and samples the cycle type.
// R06: load_or_step_n high steps the burst counter and ignores read/write.
// R07: the two low loaded address bits seed the burst counter.
// R08: read/write low on a load edge makes a write; array write self-timed; the core writes on one clock edge.
// R09: each active-low lane write enable gates its own byte lane.
// R10: controller gives lane enables with the address; they apply to its data.
// R11: cycle type is fixed only on load edges; steps inherit it.
// R12: selected when primary and low secondary are low and high secondary high.
// R13: chip selects are sampled only on load edges.
// R14: output enable gates the data drivers asynchronously.
// R15: clock suspend high holds every internal state, burst counter included.
// R16: system holds sleep request low when sleep is unused.
// R17: burst order is linear or interleaved, picked by a static order input.
// R18: order input low means linear, high means interleaved; never changed live.
// R19: sleep request high holds all state and ignores every other input; the core clears drive_reg in sleep.
// R20: bursts never change direction; all lane enables low writes the full word.
// R21: linear adds the step modulo four; interleaved xors the step.
// R22: a deselected load makes no array access and leaves the bus undriven.
package sbsi_pkg;

    localparam int unsigned ADDR_W  = 18;
    localparam int unsigned LANE_W  = 9;
    localparam int unsigned LANES   = 4;
    localparam int unsigned DATA_W  = LANE_W * LANES;
    localparam int unsigned DEPTH   = 262144;
    localparam int unsigned BURST_W = 2;
    localparam int unsigned HI_W    = ADDR_W - BURST_W;

    localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] STEP_ONE  = 2'h1;
    localparam logic [DATA_W-1:0]  DATA_ZERO = 36'h0;
    localparam logic [LANES-1:0]   LANE_NONE = 4'h0;
    localparam logic [HI_W-1:0]    HI_ZERO   = 16'h0;

    typedef enum logic [1:0] {
        CYC_DESEL = 2'b00,
        CYC_READ  = 2'b01,
        CYC_WRITE = 2'b10
    } sbsi_cyc_t;

    // low address bits of a burst beat
    function automatic logic [BURST_W-1:0] sbsi_beat_addr(
        input logic [BURST_W-1:0] base,
        input logic [BURST_W-1:0] step,
        input logic               interleave
    );
        logic [BURST_W-1:0] res;
        res = interleave ? (base ^ step) : BURST_W'(base + step);
        return res;
    endfunction

endpackage

/* File: core/sbsi_links_if.sv */
`timescale 1ns/1ps
interface sbsi_burst_if;
    import sbsi_pkg::*;
    logic                load;
    logic                step;
    logic [BURST_W-1:0]  base;
    logic                interleave;
    logic [BURST_W-1:0]  beat;
    modport ctrl (output load, output step, output base, output interleave,
                  input beat);
    modport cnt  (input load, input step, input base, input interleave,
                  output beat);
endinterface

interface sbsi_mem_if;
    import sbsi_pkg::*;
    logic [ADDR_W-1:0]  addr;
    logic               wr_en;
    logic [LANES-1:0]   lane_en;
    logic [DATA_W-1:0]  wdata;
    logic               rd_en;
    logic [DATA_W-1:0]  rdata;
    modport ctrl (output addr, output wr_en, output lane_en, output wdata,
                  output rd_en, input rdata);
    modport mem  (input addr, input wr_en, input lane_en, input wdata,
                  input rd_en, output rdata);
endinterface

/* File: core/sbsi_burst_counter.sv */
`timescale 1ns/1ps
module sbsi_burst_counter
    import sbsi_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   rst_b_i,
    sbsi_burst_if.cnt   bus
);
    import sbsi_pkg::*;

    logic [BURST_W-1:0] base_reg;
    logic [BURST_W-1:0] base_next;
    logic [BURST_W-1:0] step_reg;
    logic [BURST_W-1:0] step_next;

    always_comb
    begin
        base_next = base_reg;
        step_next = step_reg;
        if (bus.load)
        begin
            base_next = bus.base;                          // see R07
            step_next = STEP_ZERO;
        end
        else if (bus.step)
        begin
            step_next = BURST_W'(step_reg + STEP_ONE);     // see R04
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            base_reg <= STEP_ZERO;
            step_reg <= STEP_ZERO;
        end
        else
        begin
            base_reg <= base_next;
            step_reg <= step_next;
        end
    end

    assign bus.beat = sbsi_beat_addr(base_reg, step_reg,
                                     bus.interleave);      // see R21
endmodule

/* File: core/sbsi_array.sv */
`timescale 1ns/1ps
module sbsi_array
    import sbsi_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   rst_b_i,
    sbsi_mem_if.mem     port
);
    import sbsi_pkg::*;

    logic [DATA_W-1:0] cells [0:DEPTH-1];                  // see R03
    logic [DATA_W-1:0] rdata_reg;

    // single-edge write stands in for the self-timed array write
    always_ff @(posedge core_clk_i)
    begin
        if (port.wr_en)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (port.lane_en[i])                        // see R09
                begin
                    cells[port.addr][i*LANE_W +: LANE_W] <=
                        port.wdata[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_reg <= DATA_ZERO;
        end
        else if (port.rd_en)
        begin
            rdata_reg <= cells[port.addr];
        end
    end

    assign port.rdata = rdata_reg;
endmodule

/* File: testbench/sbsi_core_monitor.sv */
`timescale 1ns/1ps
module sbsi_core_monitor (
    input wire logic                        core_clk_i,
    input wire logic                        rst_b_i,
    input wire logic [sbsi_pkg::DATA_W-1:0] data_o,
    input wire logic                        data_oe_o,
    input wire logic                        chip_select_n_i,
    input wire logic                        secondary_selects_n_i,
    input wire logic                        secondary_selects_i,
    input wire logic                        load_or_step_n_i,
    input wire logic                        read_write_n_i,
    input wire logic                        clock_suspend_n_i,
    input wire logic                        output_enable_n_i,
    input wire logic                        sleep_request_i
);
    import sbsi_pkg::*;
    wire go  = !clock_suspend_n_i && !sleep_request_i;
    wire sel = !chip_select_n_i && !secondary_selects_n_i
               && secondary_selects_i;
    wire ld  = go && !load_or_step_n_i;
    wire may = data_oe_o || output_enable_n_i || sleep_request_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd;
        ld && sel && read_write_n_i;
    endsequence
    sequence s_wr;
        ld && sel && !read_write_n_i;
    endsequence
    sequence s_odd_step;
        go && load_or_step_n_i && (!read_write_n_i || chip_select_n_i);
    endsequence
    chk_read_drive: assert property (s_rd ##1 go |=> may)
        else $error("read left bus undriven");
    chk_write_float: assert property (s_wr ##1 go |=> !data_oe_o)
        else $error("write drove bus");
    chk_desel_float: assert property (ld && !sel ##1 go |=> !data_oe_o)
        else $error("deselect drove bus");
    chk_step_keeps: assert property (s_rd ##1 s_odd_step ##1 go |=> may)
        else $error("step changed cycle");
    chk_oe_async: assert property (output_enable_n_i |-> !data_oe_o)
        else $error("bus driven with oe off");
    chk_sleep_float: assert property (sleep_request_i |-> !data_oe_o)
        else $error("bus driven in sleep");
    chk_susp_hold: assert property (clock_suspend_n_i |=> $stable(data_o))
        else $error("data moved in suspend");
    chk_sleep_hold: assert property (sleep_request_i |=> $stable(data_o))
        else $error("data moved in sleep");
endmodule

/* File: testbench/sbsi_host_model.sv */
`timescale 1ns/1ps
module sbsi_host_model (
    input  wire logic                        core_clk_i,
    input  wire logic                        wr_phase_i,
    input  wire logic [sbsi_pkg::DATA_W-1:0] wdata_i,
    output logic      [sbsi_pkg::DATA_W-1:0] bus_o
);
    import sbsi_pkg::*;
    logic [DATA_W-1:0] last_reg = 36'h0;
    // released bus flips every cycle so stale data never looks valid
    assign bus_o = wr_phase_i ? wdata_i : ~last_reg;
    always_ff @(posedge core_clk_i)
    begin
        last_reg <= bus_o;
    end
endmodule

/* File: testbench/tb_sbsi_core.sv */
`timescale 1ns/1ps
module tb_sbsi_core;
    import sbsi_pkg::*;
    localparam logic [35:0] D0 = 36'h123456789, D1 = 36'h0abcdef01;
    localparam logic [35:0] D2 = 36'h9f0e1d2c3, M = 36'h007fc01ff;
    localparam logic [35:0] MIX = (D1 & ~M) | (D2 & M);
    logic        clk = 1'b0, rst_b = 1'b0;
    logic [17:0] a = 18'h0;
    logic [35:0] w = 36'h0, bus, rd, rd_q;
    logic [2:0]  cs = 3'h7;
    logic [3:0]  be = 4'hf;
    logic        ld = 1'b0, rw = 1'b1, sp = 1'b0, oen = 1'b0;
    logic        zz = 1'b0, md = 1'b0, wp = 1'b0, oe, oe_q;
    int          errors = 0, n_compared = 0;
    always #4 clk = ~clk;
    sbsi_core u_sbsi_core (.core_clk_i(clk), .rst_b_i(rst_b), .addr_i(a),
        .data_i(bus), .data_o(rd), .data_oe_o(oe), .chip_select_n_i(cs[2]),
        .secondary_selects_n_i(cs[1]), .secondary_selects_i(cs[0]),
        .load_or_step_n_i(ld), .read_write_n_i(rw), .lane_a_write_n_i(be[0]),
        .lane_b_write_n_i(be[1]), .lane_c_write_n_i(be[2]),
        .lane_d_write_n_i(be[3]), .clock_suspend_n_i(sp),
        .output_enable_n_i(oen), .sleep_request_i(zz), .burst_interleave_i(md));
    sbsi_host_model u_sbsi_host_model (.core_clk_i(clk), .wr_phase_i(wp),
        .wdata_i(w), .bus_o(bus));
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one edge: take the result of three calls back, present the next
    task automatic cmd(input logic l, r, input logic [17:0] ad,
        input logic [3:0] b, input logic [2:0] c, input logic [35:0] d);
        @(negedge clk);
        rd_q = rd;
        oe_q = oe;
        @(posedge clk);
        ld <= l;
        rw <= r;
        a <= ad;
        be <= b;
        cs <= c;
        w <= d;
        wp <= |d;
    endtask
    task automatic idle(input logic [35:0] d);
        cmd(1'b0, 1'b1, 18'h0, 4'hf, 3'h7, d);
    endtask
    task automatic rdc(input logic [17:0] ad, input logic [35:0] d);
        cmd(1'b0, 1'b1, ad, 4'hf, 3'h1, d);
    endtask
    // burst advance: keeps the current read going
    task automatic adv();
        cmd(1'b1, 1'b1, 18'h0, 4'hf, 3'h7, 36'h0);
    endtask
    task automatic t_mix();
        cmd(1'b0, 1'b0, 18'h100, 4'h0, 3'h1, 36'h0);
        cmd(1'b0, 1'b0, 18'h101, 4'h0, 3'h1, D0);
        cmd(1'b0, 1'b0, 18'h101, 4'ha, 3'h1, D1);
        rdc(18'h100, D2);
        rdc(18'h101, 36'h0);
        idle(36'h0);
        idle(36'h0);
        check(rd_q, D0);
        check(36'(oe_q), 36'h1);
        idle(36'h0);
        check(rd_q, MIX);
    endtask
    task automatic t_burst(input logic m);
        logic [1:0] j, x;
        md <= m;
        for (int k = 0; k < 5; k++)
            cmd(k > 0 && k < 4, k == 4, 18'h202, 4'h0, k == 4 ? 3'h7 : 3'h1,
                k ? 36'h59f + 36'(k) : 36'h0);
        for (int k = 0; k < 7; k++)
        begin
            cmd(k > 0 && k < 4, k == 0, 18'h201, 4'hf, k ? 3'h7 : 3'h1,
                36'h0);
            j = 2'(k - 3);
            // odd start so the two orders visit different words
            x = m ? (j ^ 2'h1) : 2'(j + 2'h1);
            if (k > 2)
                check(rd_q, 36'h5a0 + 36'(x ^ 2'h2));
        end
    endtask
    task automatic t_desel();
        logic [2:0] p[3] = '{3'h5, 3'h3, 3'h0};
        for (int i = 0; i < 3; i++)
        begin
            cmd(1'b0, 1'b1, 18'h100, 4'hf, p[i], 36'h0);
            cmd(1'b0, 1'b0, 18'h100, 4'h0, p[i], 36'h0);
            idle(36'hbad);
            idle(36'h0);
            check(36'(oe_q), 36'h0);
        end
        rdc(18'h100, 36'h0);
        repeat (3) idle(36'h0);
        check(rd_q, D0);
    endtask
    task automatic t_hold();
        rdc(18'h101, 36'h0);
        adv();
        sp <= 1'b1;
        adv();
        sp <= 1'b0;
        adv();
        check(36'(oe_q), 36'h0);
        adv();
        check(rd_q, MIX);
        check(36'(oe_q), 36'h1);
        oen <= 1'b1;
        idle(36'h0);
        check(36'(oe_q), 36'h0);
        oen <= 1'b0;
        zz <= 1'b1;
        idle(36'h0);
        check(36'(oe_q), 36'h0);
        zz <= 1'b0;
    endtask
    task automatic end_sim();
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_mix();
        t_burst(1'b0);
        t_burst(1'b1);
        t_desel();
        t_hold();
        end_sim();
    end
    initial
    begin
        #5000;
        errors++;
        end_sim();
    end
endmodule
bind sbsi_core sbsi_core_monitor u_sbsi_core_monitor (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .chip_select_n_i(chip_select_n_i),
    .secondary_selects_n_i(secondary_selects_n_i),
    .secondary_selects_i(secondary_selects_i),
    .load_or_step_n_i(load_or_step_n_i), .read_write_n_i(read_write_n_i),
    .clock_suspend_n_i(clock_suspend_n_i),
    .output_enable_n_i(output_enable_n_i),
    .sleep_request_i(sleep_request_i));
